//--- core/spf_dev.sv
// flash device end: quad page program and erase command sequencer
//
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/1ps
module spf_dev #(
    parameter int unsigned PROG_CYC  = spf_pkg::PAGE_PROGRAM_DURATION_US * spf_pkg::CLK_MHZ,
    parameter int unsigned SEC_CYC   = spf_pkg::SECTOR_ERASE_DURATION_US * spf_pkg::CLK_MHZ,
    parameter int unsigned B32_CYC   = spf_pkg::HALF_BLOCK_ERASE_DURATION_US * spf_pkg::CLK_MHZ,
    parameter int unsigned B64_CYC   = spf_pkg::FULL_BLOCK_ERASE_DURATION_US * spf_pkg::CLK_MHZ,
    parameter int unsigned CHIP_CYC  = spf_pkg::WHOLE_ARRAY_ERASE_DURATION_US * spf_pkg::CLK_MHZ
) (
    input  wire logic        clk_i, // 10 MHz core clock
    input  wire logic        rst_n_i, // async reset, active low
    spf_link_if.dev          link, // serial link
    input  wire logic        write_permit_set_i, // pulse: write enable seen
    input  wire logic        quad_lines_enable_bit_i, // quad enable status bit
    input  wire logic        addr4_mode_i, // 1: 4-byte address mode
    input  wire logic        protect_complement_bit_i, // protect complement
    input  wire logic        protect_top_bottom_bit_i, // 0 top, 1 bottom
    input  wire logic [3:0]  protect_level_i, // protect level bits 3..0
    input  wire logic        lock_hit_i, // lock set for lock_addr_o
    input  wire logic        any_lock_i, // some lock set anywhere
    output logic [31:0]      lock_addr_o, // address under lock check
    output logic             write_permit_latch_o, // latch state
    output logic             busy_o, // cycle in progress
    output logic             load_o, // pulse: page byte loaded
    output logic [31:0]      load_addr_o, // page byte address
    output logic [7:0]       load_data_o, // page byte value
    output logic             op_start_o, // pulse: cycle begins
    output spf_pkg::spf_kind_t op_kind_o, // kind of cycle
    output logic [31:0]      op_addr_o, // target address
    output logic             op_done_o // pulse: cycle ends
);
    typedef enum logic [2:0] {
        D_IDLE = 3'h0,
        D_OPC  = 3'h1,
        D_ADR  = 3'h2,
        D_DATA = 3'h3,
        D_END  = 3'h4,
        D_SKIP = 3'h5
    } spf_dstate_t;

    // ==========================================================
    // synchronisers: select, clock, four data lines
    logic [5:0] sync1, sync2;
    logic       sclk_d, cs_d;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1  <= 6'h20;
            sync2  <= 6'h20;
            sclk_d <= 1'b0;
            cs_d   <= 1'b1;
        end else begin
            sync1  <= {link.cs_n, link.sclk, link.io};
            sync2  <= sync1;
            sclk_d <= sync2[4];
            cs_d   <= sync2[5];
        end
    end

    // edge finding on the second stage only
    wire        cs_s    = sync2[5];
    wire [3:0]  io_s    = sync2[3:0];
    wire        rise    = sync2[4] & ~sclk_d & ~cs_s;
    wire        cs_fall = ~cs_s & cs_d;
    wire        cs_rise = cs_s & ~cs_d;

    // ==========================================================
    // opcode decode on the byte being completed
    spf_dstate_t     state;
    logic [7:0]      opc;
    logic [5:0]      bitc;
    logic [5:0]      alast;
    logic [31:0]     adr;
    logic [7:0]      ptr;
    logic [3:0]      nib;
    logic            half, loaded, write_permit_latch, busy;
    logic [31:0]     timer;
    spf_pkg::spf_kind_t kind;

    wire [7:0] opc_n   = {opc[6:0], io_s[0]};
    wire is_qp4   = opc_n == spf_pkg::OPC_QPROG4; // R6
    wire is_qp    = (opc_n == spf_pkg::OPC_QPROG) | is_qp4; // R1
    wire is_sec4  = opc_n == spf_pkg::OPC_SEC4; // R8
    wire is_sec   = (opc_n == spf_pkg::OPC_SEC) | is_sec4; // R7
    wire is_b32   = opc_n == spf_pkg::OPC_BLK32; // R9
    wire is_b64_4 = opc_n == spf_pkg::OPC_BLK64_4; // R11
    wire is_b64   = (opc_n == spf_pkg::OPC_BLK64) | is_b64_4; // R10
    wire is_chip  = (opc_n == spf_pkg::OPC_CHIP_A) |
        (opc_n == spf_pkg::OPC_CHIP_B); // R12
    wire is_erase = is_sec | is_b32 | is_b64 | is_chip;
    wire force4   = is_qp4 | is_sec4 | is_b64_4;
    wire wide     = force4 | addr4_mode_i; // R21
    // gate: not busy, latch set, quad enable for quad program
    wire qp_ok    = is_qp & quad_lines_enable_bit_i & write_permit_latch; // R2 R3
    wire er_ok    = is_erase & write_permit_latch; // R13
    wire accept   = ~busy & (qp_ok | er_ok); // R23
    wire spf_pkg::spf_kind_t kind_n =
        is_qp  ? spf_pkg::SPF_K_PROG :
        is_sec ? spf_pkg::SPF_K_SEC  :
        is_b32 ? spf_pkg::SPF_K_B32  :
        is_b64 ? spf_pkg::SPF_K_B64  : spf_pkg::SPF_K_CHIP;

    // ==========================================================
    // protection: level picks a top or bottom span, complement inverts
    function automatic logic prot_hit(input logic [31:0] a, input logic [3:0] lvl,
                                      input logic tb, input logic cmp);
        logic [24:0] mask;
        logic        in;
        mask = '0;
        in   = 1'b0;
        if (lvl >= spf_pkg::PROT_ALL_LEVEL) begin
            in = 1'b1;
        end else if (lvl != 4'h0) begin
            mask = ~((25'h1 << (5'(spf_pkg::PROT_BASE_EXP) + 5'(lvl))) - 25'h1);
            in   = tb ? ((a[24:0] & mask) == 25'h0) : ((a[24:0] & mask) == mask);
        end
        return in ^ cmp;
    endfunction : prot_hit

    wire any_prot = (protect_complement_bit_i ? (protect_level_i < spf_pkg::PROT_ALL_LEVEL)
        : (protect_level_i != 4'h0)) | any_lock_i;
    wire tgt_prot = prot_hit(adr, protect_level_i, protect_top_bottom_bit_i,
        protect_complement_bit_i) | lock_hit_i;
    wire blocked  = (kind == spf_pkg::SPF_K_CHIP) ? any_prot : tgt_prot; // R19 R20
    // select must rise exactly on a command boundary
    wire end_ok   = (state == D_END) | // R14 R15
        ((state == D_DATA) & loaded & ~half); // R4 R1
    wire go       = cs_rise & end_ok & ~blocked & ~busy;
    wire [31:0] dur = (kind == spf_pkg::SPF_K_PROG) ? PROG_CYC :
        (kind == spf_pkg::SPF_K_SEC) ? SEC_CYC :
        (kind == spf_pkg::SPF_K_B32) ? B32_CYC :
        (kind == spf_pkg::SPF_K_B64) ? B64_CYC : CHIP_CYC;

    // ==========================================================
    // frame sequencer: one bit or nibble per sampled link clock rise
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state  <= D_IDLE;
            opc    <= 8'h00;
            bitc   <= 6'h00;
            alast  <= 6'h00;
            adr    <= 32'h00000000;
            ptr    <= 8'h00;
            nib    <= 4'h0;
            half   <= 1'b0;
            loaded <= 1'b0;
            kind   <= spf_pkg::SPF_K_PROG;
        end else if (cs_fall) begin
            state  <= D_OPC;
            adr    <= 32'h00000000; // a 24-bit frame must not inherit upper bits
            bitc   <= 6'h00;
            half   <= 1'b0;
            loaded <= 1'b0;
        end else if (cs_rise) begin
            state  <= D_IDLE;
        end else if (rise) begin
            case (state)
                D_OPC: begin
                    opc  <= opc_n;
                    bitc <= bitc + 6'h01;
                    if (bitc == 6'h07) begin
                        bitc  <= 6'h00;
                        kind  <= kind_n;
                        alast <= wide ? 6'h1F : 6'h17;
                        if (!accept)
                            state <= D_SKIP;
                        else if (is_chip)
                            state <= D_END; // R15
                        else
                            state <= D_ADR;
                    end
                end
                D_ADR: begin
                    adr  <= {adr[30:0], io_s[0]};
                    bitc <= bitc + 6'h01;
                    if (bitc == alast) begin
                        ptr   <= {adr[6:0], io_s[0]};
                        state <= (kind == spf_pkg::SPF_K_PROG) ? D_DATA : D_END; // R14
                    end
                end
                D_DATA: begin
                    half <= ~half;
                    nib  <= io_s;
                    if (half) begin
                        ptr    <= ptr + 8'h01; // R22 R5
                        loaded <= 1'b1;
                    end
                end
                D_END:   state <= D_SKIP; // R14 R15
                default: state <= state;
            endcase
        end
    end

    // page byte output: low address byte wraps inside the page
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            load_o      <= 1'b0;
            load_addr_o <= 32'h00000000;
            load_data_o <= 8'h00;
        end else begin
            load_o <= rise & ~cs_s & (state == D_DATA) & half;
            if (rise & (state == D_DATA) & half) begin
                load_addr_o <= {adr[31:8], ptr}; // R22
                load_data_o <= {nib, io_s};
            end
        end
    end

    // ==========================================================
    // self-timed cycle and write permit latch
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            busy       <= 1'b0;
            timer      <= 32'h00000000;
            write_permit_latch        <= 1'b0;
            op_start_o <= 1'b0;
            op_done_o  <= 1'b0;
            op_kind_o  <= spf_pkg::SPF_K_PROG;
            op_addr_o  <= 32'h00000000;
        end else begin
            op_start_o <= go;
            op_done_o  <= busy & (timer == 32'h00000001);
            if (go) begin
                busy      <= 1'b1; // R16 R17
                timer     <= dur; // R16
                op_kind_o <= kind;
                op_addr_o <= adr;
            end else if (busy) begin
                timer <= timer - 32'h00000001;
                if (timer == 32'h00000001)
                    busy <= 1'b0; // R17
            end
            // a set arriving with the completion clear wins
            if (write_permit_set_i)
                write_permit_latch <= 1'b1;
            else if (busy & (timer == 32'h00000001))
                write_permit_latch <= 1'b0; // R18
        end
    end

    assign busy_o               = busy;
    assign write_permit_latch_o = write_permit_latch;
    assign lock_addr_o          = adr;
endmodule : spf_dev

//--- pkg/spf_pkg.sv
// shared constants for the serial flash program/erase link
// ==========================================================
// Behaviour
// [R1] 32h: opcode, address, quad data bytes
// [R2] quad program needs quad enable bit
// [R3] quad program needs write permit latch
// [R4] select stays low through whole program
// [R5] up to 256 bytes, like page program
// [R6] 34h always takes 32-bit address
// [R7] 20h erases addressed 4K sector
// [R8] 21h sector erase with 32-bit address
// [R9] 52h erases addressed 32K block
// [R10] D8h erases addressed 64K block
// [R11] DCh 64K erase with 32-bit address
// [R12] C7h or 60h erase whole array
// [R13] erase ignored without write permit latch
// [R14] erase select rises after last address bit
// [R15] chip erase select rises after opcode
// [R16] valid erase runs self-timed duration
// [R17] busy is 1 during cycle
// [R18] write permit latch cleared at completion
// [R19] protected sector/block erase is skipped
// [R20] chip erase refused if anything protected
// [R21] 32h/20h/52h/D8h address width follows mode
// [R22] program address wraps within the page
// [R23] no new program/erase while busy
package spf_pkg;
    // ==========================================================
    // opcodes
    localparam logic [7:0] OPC_QPROG    = 8'h32;
    localparam logic [7:0] OPC_QPROG4   = 8'h34;
    localparam logic [7:0] OPC_SEC      = 8'h20;
    localparam logic [7:0] OPC_SEC4     = 8'h21;
    localparam logic [7:0] OPC_BLK32    = 8'h52;
    localparam logic [7:0] OPC_BLK64    = 8'hD8;
    localparam logic [7:0] OPC_BLK64_4  = 8'hDC;
    localparam logic [7:0] OPC_CHIP_A   = 8'hC7;
    localparam logic [7:0] OPC_CHIP_B   = 8'h60;
    // ==========================================================
    // operation kinds reported on the user side
    typedef enum logic [2:0] {
        SPF_K_PROG  = 3'h0,
        SPF_K_SEC   = 3'h1,
        SPF_K_B32   = 3'h2,
        SPF_K_B64   = 3'h3,
        SPF_K_CHIP  = 3'h4
    } spf_kind_t;
    // ==========================================================
    // timing: durations in microseconds, clock in MHz
    localparam int unsigned CLK_MHZ                        = 10;
    localparam int unsigned PAGE_PROGRAM_DURATION_US       = 3000;
    localparam int unsigned SECTOR_ERASE_DURATION_US       = 50000;
    localparam int unsigned HALF_BLOCK_ERASE_DURATION_US   = 150000;
    localparam int unsigned FULL_BLOCK_ERASE_DURATION_US   = 200000;
    localparam int unsigned WHOLE_ARRAY_ERASE_DURATION_US  = 80000000;
    localparam int unsigned SCLK_HALF_CYC                  = 4;  // 800 ns link clock
    // ==========================================================
    // array geometry and protection
    localparam int unsigned ARRAY_ADDR_W   = 25;
    localparam int unsigned PROT_BASE_EXP  = 15;
    localparam logic [3:0]  PROT_ALL_LEVEL = 4'hA;
    // ==========================================================
    // host register offsets and fields
    localparam logic [3:0] REG_CMD    = 4'h0;
    localparam logic [3:0] REG_ADDR   = 4'h4;
    localparam logic [3:0] REG_DATA   = 4'h8;
    localparam logic [3:0] REG_STATUS = 4'hC;
    localparam int unsigned CMD_ADDR4_BIT = 8;
    localparam int unsigned CMD_HASADR_BIT = 9;
    localparam int unsigned CMD_HASDAT_BIT = 10;
    localparam int unsigned DATA_LAST_BIT = 8;
    localparam int unsigned ST_ACTIVE_BIT = 0;
    localparam int unsigned ST_NEED_BIT   = 1;
endpackage : spf_pkg

//--- pkg/spf_link_if.sv
// link between the host controller and the flash device
`timescale 1ns/1ps
interface spf_link_if;
    logic       cs_n;      // chip select, active low
    logic       sclk;      // serial clock made by the host
    logic [3:0] io_o;      // host drive value of io0..io3
    logic [3:0] io_oe_n;   // host output enable, low drives
    logic [3:0] io;        // resolved pin level
    assign io = io_o;      // only the host drives in these commands
    modport host (output cs_n, output sclk, output io_o, output io_oe_n);
    modport dev  (input cs_n, input sclk, input io);
endinterface : spf_link_if

//--- core/spf_host.sv
// host end: drives select, link clock and io from a small register port
`timescale 1ns/1ps
module spf_host (
    input  wire logic        clk_i,     // 10 MHz core clock
    input  wire logic        rst_n_i,   // async reset, active low
    spf_link_if.host         link,      // serial link
    input  wire logic [3:0]  addr_i,    // register offset
    input  wire logic [31:0] wdata_i,   // write data
    input  wire logic        wr_i,      // write strobe
    input  wire logic        rd_i,      // read strobe
    output logic [31:0]      rdata_o    // read data, cycle after rd_i
);
    typedef enum logic [1:0] {
        H_IDLE  = 2'h0,
        H_SHIFT = 2'h1,
        H_WAIT  = 2'h2,
        H_DONE  = 2'h3
    } spf_hstate_t;
    typedef enum logic [1:0] {
        P_CMD = 2'h0,
        P_ADR = 2'h1,
        P_DAT = 2'h2
    } spf_phase_t;

    spf_hstate_t state;
    spf_phase_t  phase;
    logic [31:0] sh, adr;
    logic [5:0]  cnt;
    logic [2:0]  div;
    logic        quad, sclk, cs_n, a4, has_adr, has_dat, last;

    // ==========================================================
    // register decode
    wire wr_cmd  = wr_i & (addr_i == spf_pkg::REG_CMD) & (state == H_IDLE);
    wire wr_adr  = wr_i & (addr_i == spf_pkg::REG_ADDR);
    wire wr_dat  = wr_i & (addr_i == spf_pkg::REG_DATA) & (state == H_WAIT);
    wire tick    = div == 3'(spf_pkg::SCLK_HALF_CYC - 1);
    wire active  = state != H_IDLE;
    wire need    = state == H_WAIT;
    wire [31:0] st_word = {30'h0, need, active};
    // opcode then address: width follows the CMD_ADDR4_BIT of the command write
    wire [31:0] adr_sh  = a4 ? adr : {adr[23:0], 8'h00}; // R21 R6 R8 R11

    // ==========================================================
    // link clock divider and shifter; data change on falling edges
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state   <= H_IDLE;
            phase   <= P_CMD;
            sh      <= 32'h00000000;
            adr     <= 32'h00000000;
            cnt     <= 6'h00;
            div     <= 3'h0;
            quad    <= 1'b0;
            sclk    <= 1'b0;
            cs_n    <= 1'b1;
            a4      <= 1'b0;
            has_adr <= 1'b0;
            has_dat <= 1'b0;
            last    <= 1'b0;
        end else begin
            if (wr_adr)
                adr <= wdata_i;
            div <= (state == H_IDLE || state == H_WAIT || tick) ? 3'h0 : div + 3'h1;
            case (state)
                H_IDLE: if (wr_cmd) begin
                    cs_n    <= 1'b0; // R1 R7 R12
                    sh      <= {wdata_i[7:0], 24'h000000};
                    cnt     <= 6'h08;
                    quad    <= 1'b0;
                    phase   <= P_CMD;
                    a4      <= wdata_i[spf_pkg::CMD_ADDR4_BIT];
                    has_adr <= wdata_i[spf_pkg::CMD_HASADR_BIT];
                    has_dat <= wdata_i[spf_pkg::CMD_HASDAT_BIT];
                    state   <= H_SHIFT;
                end
                H_SHIFT: if (tick) begin
                    sclk <= ~sclk;
                    if (sclk) begin
                        sh  <= quad ? {sh[27:0], 4'h0} : {sh[30:0], 1'b0};
                        cnt <= cnt - 6'h01;
                        if (cnt == 6'h01) begin
                            if (phase == P_CMD && has_adr) begin
                                sh    <= adr_sh;
                                cnt   <= a4 ? 6'h20 : 6'h18;
                                phase <= P_ADR;
                            end else if (phase != P_DAT && has_dat) begin
                                state <= H_WAIT; // R4
                            end else if (phase == P_DAT && !last) begin
                                state <= H_WAIT; // R4
                            end else begin
                                state <= H_DONE; // R14 R15
                            end
                        end
                    end
                end
                H_WAIT: if (wr_dat) begin
                    sh    <= {wdata_i[7:0], 24'h000000}; // R1
                    cnt   <= 6'h02;
                    quad  <= 1'b1;
                    phase <= P_DAT;
                    last  <= wdata_i[spf_pkg::DATA_LAST_BIT];
                    state <= H_SHIFT;
                end
                H_DONE: if (tick) begin
                    cs_n  <= 1'b1; // R14 R15
                    state <= H_IDLE;
                end
                default: state <= H_IDLE;
            endcase
        end
    end

    // read port: one cycle latency, unmapped offsets read zero
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            rdata_o <= 32'h00000000;
        else if (rd_i)
            rdata_o <= (addr_i == spf_pkg::REG_STATUS) ? st_word :
                       (addr_i == spf_pkg::REG_ADDR)   ? adr : 32'h00000000;
    end

    assign link.cs_n    = cs_n;
    assign link.sclk    = sclk;
    assign link.io_o    = quad ? sh[31:28] : {3'h0, sh[31]};
    assign link.io_oe_n = cs_n ? 4'hF : (quad ? 4'h0 : 4'hE);
endmodule : spf_host

//--- dv/spf_link_properties.sv
// link and sequencer assertions for the program/erase pair
`timescale 1ns/1ps
module spf_link_properties #(
    parameter int unsigned PROG_CYC = 40,
    parameter int unsigned SEC_CYC  = 300,
    parameter int unsigned B32_CYC  = 320,
    parameter int unsigned B64_CYC  = 340,
    parameter int unsigned CHIP_CYC = 360
) (
    input wire logic               clk_i, // core clock
    input wire logic               rst_n_i, // reset, active low
    input wire logic               cs_n, // select
    input wire logic               sclk, // link clock
    input wire logic               busy_o, // cycle running
    input wire logic               op_start_o, // cycle begins
    input wire logic               op_done_o, // cycle ends
    input wire spf_pkg::spf_kind_t op_kind_o, // kind of cycle
    input wire logic               write_permit_latch_o, // latch
    input wire logic               quad_lines_enable_bit_i // quad enable
);
    // ==========================================================
    // busy length: spans too long to repeat
    logic [31:0] busy_cnt;
    wire  [31:0] want_cnt = (op_kind_o == spf_pkg::SPF_K_PROG) ? PROG_CYC :
        (op_kind_o == spf_pkg::SPF_K_SEC) ? SEC_CYC :
        (op_kind_o == spf_pkg::SPF_K_B32) ? B32_CYC :
        (op_kind_o == spf_pkg::SPF_K_B64) ? B64_CYC : CHIP_CYC;
    // busy already stands in the cycle that shows the start pulse
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) busy_cnt <= 32'h0;
        else if (op_start_o) busy_cnt <= 32'h1;
        else if (busy_o) busy_cnt <= busy_cnt + 32'h1;
    end
    // ==========================================================
    // properties
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    property p_sclk_idle; cs_n |-> !sclk; endproperty
    a_sclk_idle: assert property (p_sclk_idle) else $error("sclk while idle");
    property p_sclk_high; $rose(sclk) |-> sclk[*4] ##1 !sclk; endproperty
    a_sclk_high: assert property (p_sclk_high) else $error("sclk high phase");
    property p_busy_go; op_start_o |=> busy_o; endproperty
    a_busy_go: assert property (p_busy_go) else $error("no busy after start");
    property p_done_fall; op_done_o |-> $fell(busy_o); endproperty
    a_done_fall: assert property (p_done_fall) else $error("done, busy kept");
    property p_no_start; op_start_o |-> !$past(busy_o); endproperty
    a_no_start: assert property (p_no_start) else $error("start while busy");
    property p_start_wpl; op_start_o |-> write_permit_latch_o; endproperty
    a_start_wpl: assert property (p_start_wpl) else $error("start without latch");
    property p_start_qe; op_start_o && op_kind_o == spf_pkg::SPF_K_PROG |-> quad_lines_enable_bit_i;
    endproperty
    a_start_qe: assert property (p_start_qe) else $error("program without quad");
    property p_wpl_clr; op_done_o |-> ##[0:1] !write_permit_latch_o; endproperty
    a_wpl_clr: assert property (p_wpl_clr) else $error("latch kept");
    property p_busy_len; op_done_o |-> busy_cnt == want_cnt; endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
endmodule : spf_link_properties

//--- dv/testbench.sv
// self-checking bench: host and flash ends joined over the link
`timescale 1ns/1ps
module testbench;
    // ==========================================================
    // signals and command table
    typedef struct packed {
        logic [7:0]  op;   // opcode
        logic        a32;  // 32-bit address
        logic        m4;   // 4-byte mode
        logic        adr;  // has address
        logic [2:0]  kind; // expected kind
        logic [31:0] addr; // target
    } spf_row_t;
    logic               clk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
    logic               wps = 1'b0, qe = 1'b1, m4 = 1'b0, wpl, busy_o, load_o, st, dn;
    logic               cmp = 1'b0, tb = 1'b0, lh = 1'b0, al = 1'b0;
    logic [7:0]         ld;
    logic [3:0]         addr_i = 4'h0, lvl = 4'h0;
    logic [31:0]        wdata_i = 32'h0, rdata_o, load_addr_o, op_addr_o, v, a_seen, l_seen;
    spf_pkg::spf_kind_t kind, k_seen;
    int                 err_count = 0, cmp_count = 0, n_start = 0, n_done = 0, s;
    spf_row_t rows [10] = '{
        '{8'h20, 1'b0, 1'b0, 1'b1, 3'h1, 32'h0001_2000}, '{8'h21, 1'b1, 1'b0, 1'b1, 3'h1, 32'h0102_3000},
        '{8'h20, 1'b1, 1'b1, 1'b1, 3'h1, 32'h0104_5000}, '{8'h52, 1'b0, 1'b0, 1'b1, 3'h2, 32'h0003_8000},
        '{8'hD8, 1'b0, 1'b0, 1'b1, 3'h3, 32'h0005_0000}, '{8'hDC, 1'b1, 1'b0, 1'b1, 3'h3, 32'h0106_0000},
        '{8'hC7, 1'b0, 1'b0, 1'b0, 3'h4, 32'h0000_0000}, '{8'h60, 1'b0, 1'b0, 1'b0, 3'h4, 32'h0000_0000},
        '{8'h32, 1'b0, 1'b0, 1'b1, 3'h0, 32'h0000_21FF}, '{8'h34, 1'b1, 1'b0, 1'b1, 3'h0, 32'h0100_33FF}};
    spf_link_if link ();
    spf_host spf_host_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(link), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o));
    spf_dev #(.PROG_CYC(40), .SEC_CYC(300), .B32_CYC(320), .B64_CYC(340), .CHIP_CYC(360))
        spf_dev_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(link), .write_permit_set_i(wps),
        .quad_lines_enable_bit_i(qe), .addr4_mode_i(m4), .protect_complement_bit_i(cmp),
        .protect_top_bottom_bit_i(tb), .protect_level_i(lvl), .lock_hit_i(lh),
        .any_lock_i(al), .lock_addr_o(), .write_permit_latch_o(wpl), .busy_o(busy_o),
        .load_o(load_o), .load_addr_o(load_addr_o), .load_data_o(ld), .op_start_o(st),
        .op_kind_o(kind), .op_addr_o(op_addr_o), .op_done_o(dn));
    spf_link_properties spf_link_properties_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .cs_n(link.cs_n), .sclk(link.sclk), .busy_o(busy_o), .op_start_o(st), .op_done_o(dn),
        .op_kind_o(kind), .write_permit_latch_o(wpl), .quad_lines_enable_bit_i(qe));
    // 10 MHz core clock
    always #50 clk_i = ~clk_i;
    // record starts, ends, last page byte
    always @(posedge clk_i) begin
        if (st === 1'b1) begin
            n_start <= n_start + 1;
            k_seen  <= kind;
            a_seen  <= op_addr_o;
        end
        if (dn === 1'b1) n_done <= n_done + 1;
        if (load_o === 1'b1) l_seen <= {load_addr_o[23:0], ld};
    end
    // ==========================================================
    // tasks
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    // one strobe cycle; read data is taken in the cycle after the strobe
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= w;
        rd_i    <= !w;
        @(posedge clk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        #1 v = rdata_o;
    endtask : bus
    task automatic arm(input spf_row_t r, input int nb, input logic write_permit_latch);
        @(posedge clk_i);
        wps <= write_permit_latch;
        m4  <= r.m4;
        @(posedge clk_i);
        wps <= 1'b0;
        bus(1'b1, spf_pkg::REG_ADDR, r.addr);
        bus(1'b1, spf_pkg::REG_CMD, {21'h0, nb > 0, r.adr, r.a32, r.op});
        for (int i = 0; i < nb; i++) begin
            v = 32'h0;
            for (int t = 0; t < 400 && v[1] !== 1'b1; t++) bus(1'b0, spf_pkg::REG_STATUS, 32'h0);
            bus(1'b1, spf_pkg::REG_DATA, {23'h0, i == nb - 1, 8'hA5});
        end
    endtask : arm
    task automatic run(input spf_row_t r, input int nb, input logic write_permit_latch, input logic go);
        int s0, d0;
        s0 = n_start;
        d0 = n_done;
        arm(r, nb, write_permit_latch);
        for (int t = 0; t < 1500 && go && n_done == d0; t++) @(posedge clk_i);
        if (!go) repeat (600) @(posedge clk_i);
        #1 chk("starts", s0 + go, n_start);
        if (go) begin
            chk("kind", r.kind, k_seen);
            chk("latch", 32'h0, wpl);
            if (r.kind == 3'h0) chk("wrap", {r.addr[23:8], 16'h00A5}, l_seen);
            else if (r.adr) chk("addr", r.addr, a_seen);
        end
    endtask : run
    task automatic wrap_up;
        if (err_count == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up
    // ==========================================================
    // main sequence: table first, then refusals and the busy case
    initial begin
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        #1 chk("busy", 32'h0, busy_o);
        repeat (4) @(posedge clk_i);
        foreach (rows[i]) run(rows[i], rows[i].kind == 3'h0 ? 2 : 0, 1'b1, 1'b1);
        run(rows[0], 0, 1'b0, 1'b0);
        qe <= 1'b0;
        run(rows[8], 2, 1'b1, 1'b0);
        qe  <= 1'b1;
        lvl <= 4'hA;
        run(rows[0], 0, 1'b1, 1'b0);
        lvl <= 4'h0;
        al  <= 1'b1;
        run(rows[6], 0, 1'b1, 1'b0);
        al  <= 1'b0;
        s = n_start;
        arm(rows[0], 0, 1'b1);
        for (int t = 0; t < 600 && n_start == s; t++) @(posedge clk_i);
        run(rows[6], 0, 1'b1, 1'b0);
        wrap_up();
    end
    // watchdog against a hung handshake
    initial begin
        repeat (60000) @(posedge clk_i);
        err_count++;
        wrap_up();
    end
endmodule : testbench
